// ==== pkg/itr_pkg.sv ====
package itr_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CPU_PRIORITY_CONTROL = 8'h00;
  localparam logic [7:0] REG_ACT_ENABLE           = 8'h04;
  localparam logic [7:0] REG_DESCRIPTOR_MODE      = 8'h08;
  localparam logic [7:0] REG_DMA_CH_BASE          = 8'h10;
  localparam logic [7:0] REG_STATUS               = 8'h30;

  // cpu_priority_control field positions
  localparam int CPC_CPU_LVL_LSB  = 0;
  localparam int CPC_XFER_LVL_LSB = 4;
  localparam int CPC_AUTO_BIT     = 8;
  localparam int CPC_GATE_BIT     = 9;

  // dma_channel_control field positions
  localparam int DCC_SRC_LSB      = 0;
  localparam int DCC_LVL_LSB      = 8;
  localparam int DCC_FACT_LO_BIT  = 12;
  localparam int DCC_FACT_HI_BIT  = 13;
  localparam int DCC_CLR_EN_BIT   = 14;
  localparam int DCC_CH_EN_BIT    = 15;

  // Reset values and fixed levels
  localparam logic [2:0]  LVL_RESET  = 3'h0;
  localparam logic [2:0]  LVL_NMI    = 3'h7;
  localparam logic [31:0] REG_RESET  = 32'h0;

  // Interrupt control modes
  typedef enum logic [1:0]
  {
    ITR_MODE0 = 2'b00,
    ITR_MODE2 = 2'b10
  } itr_mode_t;

endpackage : itr_pkg

// ==== verilog/itr_route.sv ====
// Function
// - DMA channel with enable, clear enable and factor bits 10 claims its source exclusively
// - Unclaimed source: activation bit picks unit or CPU
// - Irq-select set: clear enable, interrupt CPU
// - Count reaches zero: clear enable, interrupt CPU
// - DMA off/enable off: CPU only; src_clear_out stays low
// - Unit only: source cleared by transfer
// - Unit and CPU share; flag stays set
// - Unit sources picked by fixed priority
// - Shared source: transfer before CPU exception
// - Gating only while gate enable is set
// - Unit held while CPU level exceeds it
// - DMA channel held when below CPU level
// - One unit priority level for all sources
// - Auto-assign tracks CPU mask, else software
// - Mode 0: mask bit into top bit
// - Mode 2: extended mask copied directly
// - CPU level writes ignored while auto-assign set
// - Serial/converter source cleared by data access when DMA-claimed or unit-only
// - Mode 2 acceptance rewrites mask; NMI seven
module itr_route
  import itr_pkg::*;
#(
  parameter int NSRC = 16,
  parameter int NCH  = 4,
  parameter int SW   = 4
)
(
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  // APB slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  // Interrupt sources and CPU state
  input  wire logic [NSRC-1:0]  src_req_in,
  input  wire logic [NSRC-1:0]  src_data_access_in,
  input  wire logic [1:0]       irq_mode_in,
  input  wire logic             cpu_mask_bit_in,
  input  wire logic [2:0]       extended_mask_level_in,
  // Transfer unit completion
  input  wire logic             xfer_done_in,
  input  wire logic [SW-1:0]    xfer_src_in,
  input  wire logic             xfer_count_zero_in,
  // Routed requests
  output logic [NSRC-1:0]       cpu_irq_out,
  output logic                  xfer_start_out,
  output logic [SW-1:0]         xfer_src_out,
  output logic [NCH-1:0]        dma_req_out,
  output logic [NSRC-1:0]       src_clear_out
);

  // Software-visible state
  logic [2:0]      cpu_priority_level;
  logic [2:0]      transfer_priority_level;
  logic            priority_auto_assign;
  logic            priority_gate_enable;
  logic [NSRC-1:0] transfer_activation_enable;
  logic [NSRC-1:0] cpu_irq_select;
  logic [31:0]     dma_channel_control [NCH];

  // Derived routing
  logic [NSRC-1:0] dma_claim;
  logic [NSRC-1:0] xfer_pend;
  logic            xfer_gate_ok;
  logic [NCH-1:0]  ch_gate_ok;
  logic [2:0]      auto_level;
  logic            busy;
  logic [NSRC-1:0] cpu_hold;
  logic            wr_en;
  logic            rd_en;
  logic [31:0]     next_prdata;
  logic            next_slverr;
  logic [SW-1:0]   pick;
  logic            pick_valid;

  // Channel field decode, used in several places
  function automatic logic ch_active(input logic [31:0] c);
    ch_active = c[DCC_CH_EN_BIT] & c[DCC_FACT_HI_BIT] & ~c[DCC_FACT_LO_BIT]
                & c[DCC_CLR_EN_BIT];
  endfunction : ch_active

  assign wr_en = psel_in & penable_in & pwrite_in & pready_out;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;

  // Claim mask from active channels
  always_comb
  begin
    dma_claim = '0;
    for (int c = 0; c < NCH; c++)
    begin
      if (ch_active(dma_channel_control[c]))
      begin
        dma_claim[dma_channel_control[c][DCC_SRC_LSB +: SW]] = 1'b1;
      end
    end
  end

  // Auto level follows mask; mode 2 acceptance already updated the mask
  always_comb
  begin
    if (irq_mode_in == ITR_MODE2)
    begin
      auto_level = extended_mask_level_in;
    end
    else
    begin
      auto_level = {cpu_mask_bit_in, 2'b00};
    end
  end

  // Combinational gate, so a hold lifts on the next edge
  assign xfer_gate_ok = ~priority_gate_enable
                        | (cpu_priority_level <= transfer_priority_level);

  // Equal levels let the channel keep running
  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      assign ch_gate_ok[g] = ~priority_gate_enable
        | (dma_channel_control[g][DCC_LVL_LSB +: 3] >= cpu_priority_level);
    end
  endgenerate

  // A flag being cleared still reads set for one more edge; masking it
  // keeps one request from starting a second transfer
  assign xfer_pend = src_req_in & ~dma_claim & transfer_activation_enable
                     & ~src_clear_out;

  // Fixed priority: lowest source number wins, levels ignored
  always_comb
  begin
    pick       = '0;
    pick_valid = 1'b0;
    for (int s = NSRC - 1; s >= 0; s--)
    begin
      if (xfer_pend[s])
      begin
        pick       = SW'(s);
        pick_valid = 1'b1;
      end
    end
  end

  // A set enable keeps the CPU off the source: unit-only sources reach it only after
  // count zero clears the enable, shared ones wait until the transfer clears the enable
  assign cpu_hold = transfer_activation_enable;

  // CPU priority control register
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cpu_priority_level      <= LVL_RESET;
      transfer_priority_level <= LVL_RESET;
      priority_auto_assign    <= 1'b0;
      priority_gate_enable    <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr_in == REG_CPU_PRIORITY_CONTROL)
      begin
        transfer_priority_level <= pwdata_in[CPC_XFER_LVL_LSB +: 3];
        priority_auto_assign    <= pwdata_in[CPC_AUTO_BIT];
        priority_gate_enable    <= pwdata_in[CPC_GATE_BIT];
      end
      // Tracking beats a software write of the level in the same cycle
      if (priority_auto_assign)
      begin
        cpu_priority_level <= auto_level;
      end
      else if (wr_en && paddr_in == REG_CPU_PRIORITY_CONTROL)
      begin
        cpu_priority_level <= pwdata_in[CPC_CPU_LVL_LSB +: 3];
      end
    end
  end

  // Activation enables; completion clear beats a software write
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      transfer_activation_enable <= '0;
      cpu_irq_select             <= '0;
    end
    else
    begin
      if (wr_en && paddr_in == REG_ACT_ENABLE)
      begin
        transfer_activation_enable <= pwdata_in[NSRC-1:0];
      end
      if (wr_en && paddr_in == REG_DESCRIPTOR_MODE)
      begin
        cpu_irq_select <= pwdata_in[NSRC-1:0];
      end
      if (xfer_done_in && (cpu_irq_select[xfer_src_in] || xfer_count_zero_in))
      begin
        transfer_activation_enable[xfer_src_in] <= 1'b0;
      end
    end
  end

  // DMA channel control registers
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        dma_channel_control[c] <= REG_RESET;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (wr_en && paddr_in == REG_DMA_CH_BASE + 8'(4 * c))
        begin
          dma_channel_control[c] <= pwdata_in;
        end
      end
    end
  end

  // Transfer unit start, one request in flight
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      busy           <= 1'b0;
      xfer_start_out <= 1'b0;
      xfer_src_out   <= '0;
    end
    else
    begin
      xfer_start_out <= 1'b0;
      // Done is served first, so a start never meets a done
      if (xfer_done_in)
      begin
        busy <= 1'b0;
      end
      else if (!busy && pick_valid && xfer_gate_ok)
      begin
        busy           <= 1'b1;
        xfer_start_out <= 1'b1;
        xfer_src_out   <= pick;
      end
    end
  end

  // CPU requests, DMA requests and source clears
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cpu_irq_out   <= '0;
      dma_req_out   <= '0;
      src_clear_out <= '0;
    end
    else
    begin
      // CPU gets unclaimed sources that no unit route holds
      cpu_irq_out <= src_req_in & ~dma_claim & ~cpu_hold;
      for (int c = 0; c < NCH; c++)
      begin
        dma_req_out[c] <= ch_active(dma_channel_control[c]) & ch_gate_ok[c]
          & src_req_in[dma_channel_control[c][DCC_SRC_LSB +: SW]];
      end
      // Cleared only by a claiming DMA or a unit-only route
      src_clear_out <= src_data_access_in
        & (dma_claim | (transfer_activation_enable & ~cpu_irq_select));
    end
  end

  // APB read mux and unmapped error
  always_comb
  begin
    next_prdata = '0;
    next_slverr = 1'b0;
    unique case (paddr_in)
      REG_CPU_PRIORITY_CONTROL:
      begin
        next_prdata[CPC_CPU_LVL_LSB +: 3]  = cpu_priority_level;
        next_prdata[CPC_XFER_LVL_LSB +: 3] = transfer_priority_level;
        next_prdata[CPC_AUTO_BIT]          = priority_auto_assign;
        next_prdata[CPC_GATE_BIT]          = priority_gate_enable;
      end
      REG_ACT_ENABLE:      next_prdata[NSRC-1:0] = transfer_activation_enable;
      REG_DESCRIPTOR_MODE: next_prdata[NSRC-1:0] = cpu_irq_select;
      // Live routing state, read-only
      REG_STATUS:
      begin
        next_prdata[NSRC-1:0] = dma_claim;
        next_prdata[16]       = busy;
        next_prdata[17]       = xfer_gate_ok;
        next_prdata[24 +: NCH] = ch_gate_ok;
      end
      default:
      begin
        next_slverr = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
          if (paddr_in == REG_DMA_CH_BASE + 8'(4 * c))
          begin
            next_prdata = dma_channel_control[c];
            next_slverr = 1'b0;
          end
        end
      end
    endcase
  end

  // Ready in access phase: one wait-free access cycle
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end
    else
    begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & next_slverr;
      if (rd_en)
      begin
        prdata_out <= next_prdata;
      end
    end
  end

endmodule : itr_route

// ==== bench/itr_route_monitor.sv ====
module itr_route_monitor
#(
  parameter int NSRC = 16,
  parameter int SW   = 4
)
(
  // Clock, reset and APB
  input wire logic            mclk_in,
  input wire logic            srst_in,
  input wire logic            psel_in,
  input wire logic            penable_in,
  input wire logic            pwrite_in,
  input wire logic [31:0]     prdata_out,
  input wire logic            pready_out,
  input wire logic            pslverr_out,
  // Routing
  input wire logic [NSRC-1:0] src_req_in,
  input wire logic            xfer_done_in,
  input wire logic            xfer_start_out,
  input wire logic [SW-1:0]   xfer_src_out,
  input wire logic [NSRC-1:0] cpu_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic            busy;
  logic [NSRC-1:0] req_q;
  // Transfer in flight from start to done; requests one cycle back
  always_ff @(posedge mclk_in)
  begin
    busy  <= srst_in ? 1'b0 : (busy | xfer_start_out) & ~xfer_done_in;
    req_q <= src_req_in;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  property p_ready; psel_in && !penable_in |=> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("setup not answered");
  property p_once; pready_out |=> !pready_out; endproperty
  a_once: assert property (p_once) else $error("ready too long");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_err0; pslverr_out && !pwrite_in |-> prdata_out == 32'h0; endproperty
  a_err0: assert property (p_err0) else $error("refused read not zero");
  property p_pulse; xfer_start_out |=> !xfer_start_out; endproperty
  a_pulse: assert property (p_pulse) else $error("start not a pulse");
  property p_busy; xfer_start_out |-> !busy; endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_cause; xfer_start_out |-> req_q[xfer_src_out]; endproperty
  a_cause: assert property (p_cause) else $error("start without request");
  property p_hold; busy |-> !$rose(cpu_irq_out[xfer_src_out]); endproperty
  a_hold: assert property (p_hold) else $error("cpu raised mid transfer");
endmodule : itr_route_monitor
bind itr_route itr_route_monitor #(.NSRC(NSRC), .SW(SW)) u_mon (.mclk_in, .srst_in, .psel_in,
  .penable_in, .pwrite_in, .prdata_out, .pready_out, .pslverr_out, .src_req_in,
  .xfer_done_in, .xfer_start_out, .xfer_src_out, .cpu_irq_out);

// ==== bench/itr_xfer_model.sv ====
module itr_xfer_model
(
  // Clock, reset, bench controls
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic [15:0] set_in,
  input  wire logic        slow_in,
  // Block side
  input  wire logic        start_in,
  input  wire logic [3:0]  src_in,
  input  wire logic [15:0] clear_in,
  output logic      [15:0] req_out,
  output logic             done_out,
  output logic      [3:0]  done_src_out,
  output logic      [15:0] access_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  logic [3:0] src_q;
  // Source flags stay up until the block clears them
  always_ff @(posedge mclk_in)
  begin
    req_out <= srst_in ? 16'h0 : (req_out | set_in) & ~clear_in;
  end
  // One transfer at a time, one or four cycles long
  always_ff @(posedge mclk_in)
  begin
    done_out <= cnt == 3'h1;
    if (srst_in)
    begin
      cnt   <= 3'h0;
      src_q <= 4'h0;
      done_out <= 1'b0;
    end
    else if (start_in)
    begin
      cnt   <= slow_in ? 3'h4 : 3'h1;
      src_q <= src_in;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  // Source index is junk outside the done pulse; done also touches data
  assign done_src_out = done_out ? src_q : ~src_q;
  assign access_out   = done_out ? 16'h1 << src_q : 16'h0;
endmodule : itr_xfer_model

// ==== bench/itr_route_test.sv ====
module itr_route_test
  import itr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CP = REG_CPU_PRIORITY_CONTROL;
  localparam logic [7:0] AE = REG_ACT_ENABLE;
  // Bench signals
  logic        mclk_in, srst_in, psel, penable, pwrite, mask, slow, czero, perr;
  logic        pready_out, pslverr_out, xdone, xfer_start_out;
  logic [1:0]  mode;
  logic [2:0]  ext;
  logic [3:0]  xsrc, xfer_src_out, dma_req_out, dseen, lsrc;
  logic [7:0]  paddr;
  logic [15:0] set, src_req, access, cpu_irq_out, src_clear_out, clr_seen;
  logic [31:0] pwdata, rdata, prdata_out;
  int          miscompares, cmp_count, nst;
  itr_route dut (.mclk_in, .srst_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out, .pready_out, .pslverr_out,
    .src_req_in(src_req), .src_data_access_in(access), .irq_mode_in(mode),
    .cpu_mask_bit_in(mask), .extended_mask_level_in(ext), .xfer_done_in(xdone),
    .xfer_src_in(xsrc), .xfer_count_zero_in(czero), .cpu_irq_out, .xfer_start_out,
    .xfer_src_out, .dma_req_out, .src_clear_out);
  itr_xfer_model u_xfer (.mclk_in, .srst_in, .set_in(set), .slow_in(slow),
    .start_in(xfer_start_out), .src_in(xfer_src_out), .clear_in(src_clear_out),
    .req_out(src_req), .done_out(xdone), .done_src_out(xsrc), .access_out(access));
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // Falling edge sampling keeps clears in tasks race free
  always @(negedge mclk_in)
  begin
    nst      = nst + (xfer_start_out === 1'b1);
    lsrc     = xfer_start_out === 1'b1 ? xfer_src_out : lsrc;
    clr_seen = clr_seen | src_clear_out;
    dseen    = dseen | dma_req_out;
  end
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  task rst;
    srst_in <= 1'b1;
    set <= 16'h0;
    slow <= 1'b0;
    czero <= 1'b0;
    {nst, clr_seen, dseen} = 0;
    tick(3);
    srst_in <= 1'b0;
    tick(1);
  endtask : rst
  // APB master: holds the request until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready_out !== 1'b1) tick(1);
    rdata = prdata_out;
    perr = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb
  task raise(input logic [15:0] m);
    set <= m;
    tick(1);
    set <= 16'h0;
    tick(5);
  endtask : raise
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task t_regs;
    rst();
    apb(0, CP, 0);
    chk(rdata, REG_RESET);
    apb(0, 8'h3C, 0);
    chk(32'(perr), 32'h1);
    chk(rdata, 32'h0);
    apb(1, CP, 32'h7);
    apb(0, CP, 0);
    chk(rdata & 7, 7);
    mode <= ITR_MODE2;
    ext <= 3'h5;
    apb(1, CP, 32'h100);
    apb(1, CP, 32'h102);
    apb(0, CP, 0);
    chk(rdata & 7, 5);
    ext <= LVL_NMI;
    tick(1);
    apb(0, CP, 0);
    chk(rdata & 7, LVL_NMI);
    mode <= ITR_MODE0;
    mask <= 1'b1;
    tick(1);
    apb(0, CP, 0);
    chk(rdata & 7, 4);
    $display("t_regs done");
  endtask : t_regs
  task t_route;
    rst();
    raise(16'h8);
    chk({nst[15:0], cpu_irq_out}, 32'h8);
    apb(1, AE, 32'h204);
    raise(16'h204);
    tick(6);
    chk(32'(lsrc), 32'h9);
    chk(nst, 2);
    chk({clr_seen & 16'h204, cpu_irq_out & 16'h204}, 32'h02040000);
    $display("t_route done");
  endtask : t_route
  task t_share;
    rst();
    slow <= 1'b1;
    apb(1, REG_DESCRIPTOR_MODE, 32'h20);
    apb(1, AE, 32'h20);
    apb(1, CP, 32'h200);
    raise(16'h20);
    chk(32'(cpu_irq_out[5]), 32'h0);
    tick(4);
    apb(0, AE, 0);
    chk(rdata, 32'h0);
    chk(32'(cpu_irq_out[5]), 32'h1);
    chk(32'(clr_seen), 32'h0);
    rst();
    czero <= 1'b1;
    apb(1, AE, 32'h40);
    raise(16'h40);
    apb(0, AE, 0);
    chk(rdata, 0);
    $display("t_share done");
  endtask : t_share
  task t_gate;
    rst();
    apb(1, AE, 32'h20);
    apb(1, CP, 32'h234);
    raise(16'h20);
    chk(nst, 0);
    apb(1, CP, 32'h233);
    tick(3);
    chk(nst, 1);
    apb(1, CP, 32'h7);
    raise(16'h20);
    chk(nst, 2);
    $display("t_gate done");
  endtask : t_gate
  task t_dma;
    rst();
    apb(1, REG_DMA_CH_BASE, 32'hE507);
    apb(1, AE, 32'h80);
    apb(1, CP, 32'h7);
    raise(16'h80);
    chk(nst, 0);
    chk(32'(cpu_irq_out), 32'h0);
    chk(32'(dseen), 32'h1);
    apb(1, CP, 32'h206);
    dseen = 0;
    raise(16'h80);
    chk(dseen, 0);
    apb(1, CP, 32'h205);
    raise(16'h80);
    chk(dseen, 1);
    $display("t_dma done");
  endtask : t_dma
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Stimulus
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, mode, mask, ext, lsrc} <= 0;
    {miscompares, cmp_count} = 0;
    t_regs();
    t_route();
    t_share();
    t_gate();
    t_dma();
    test_done();
  end
  // Watchdog well past the some 170 cycles of the run
  initial
  begin
    tick(5000);
    miscompares++;
    test_done();
  end
endmodule : itr_route_test
